// >>> verilog/ierl_pkg.sv
// constants for the isolated edge pulse link with refresh
package ierl_pkg;
   localparam int unsigned CLK_MHZ       = 125;   // core clock rate in MHz
   localparam int unsigned CLK_PERIOD_PS = 8000;  // core clock period in ps
   localparam int unsigned PULSE_NS      = 1;     // width of a barrier pulse
   localparam int unsigned IDLE_US       = 1;     // idle time before refresh
   localparam int unsigned FAIL_US       = 1;     // silence before fail-safe
   // pulse width rounds down, never below one cycle
   localparam int unsigned PULSE_CYC_RAW = (PULSE_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned PULSE_CYC     = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
   // timeouts are longest times: round down
   localparam int unsigned IDLE_CYC      = IDLE_US * CLK_MHZ;
   localparam int unsigned FAIL_CYC      = FAIL_US * CLK_MHZ;
   localparam int unsigned CNT_W         = 12;    // timer width
   localparam logic        FAILSAFE_LVL  = 1'b1;  // output level with no pulses
   localparam logic        DEC_RST_LVL   = 1'b0;  // decoder level after reset
endpackage

// >>> verilog/ierl_channel.sv
// one isolated channel: edge encoder, refresh engine, bistable decoder, watchdog
`timescale 1ns/1ps

// What this block does
// - each input change sends one set/reset pulse
// - decoder set by set, reset by reset
// - output pair follows decoder state normally
// - refresh pulses after one microsecond idle
// - fixed variant keeps refresh always on
// - wrong power-up state fixed within 1 us
// - no pulses for 1 us forces high
// - refresh off: only transitions correct output
// - receiver slices differential input at zero
// - high: plus sources, minus sinks; low reversed
module ierl_channel
   import ierl_pkg::*;
#(
   parameter bit          FIXED_REFRESH = 1'b0,      // package with refresh always on
   parameter int unsigned IDLE_CYCLES   = IDLE_CYC,  // idle time in cycles
   parameter int unsigned FAIL_CYCLES   = FAIL_CYC   // watchdog time in cycles
) (
   input  wire logic clk_i,                  // core clock, 125 MHz
   input  wire logic rst_i,                  // synchronous reset, high
   input  wire logic diff_input_pair_p_i,    // noninverted input (sliced)
   input  wire logic diff_input_pair_n_i,    // inverted input (sliced)
   input  wire logic refresh_in_n_i,         // input-side refresh enable, low
   input  wire logic refresh_out_n_i,        // output-side refresh enable, low
   input  wire logic input_side_up_i,        // input side powered
   output logic      diff_output_pair_p_o,   // noninverted output
   output logic      diff_output_pair_n_o,   // inverted output
   output logic      set_pulse_o,            // barrier set pulse
   output logic      reset_pulse_o           // barrier reset pulse
);
   import ierl_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [1:0] sync_p;     // positive leg, two stages
   logic [1:0] sync_n;     // negative leg, two stages
   logic [1:0] sync_ri;    // refresh enable, input side
   logic [1:0] sync_ro;    // refresh enable, output side
   logic [1:0] sync_up;    // input side power

   // every input but clk_i and rst_i passes two flops before any logic looks at it
   always_ff @(posedge clk_i) begin
      sync_p  <= {sync_p[0],  diff_input_pair_p_i};
      sync_n  <= {sync_n[0],  diff_input_pair_n_i};
      sync_ri <= {sync_ri[0], refresh_in_n_i};
      sync_ro <= {sync_ro[0], refresh_out_n_i};
      sync_up <= {sync_up[0], input_side_up_i};
   end

   // ------------------------------------------------------------
   // receiver and encoder
   // ------------------------------------------------------------
   wire logic rx_level;     // recovered input state
   wire logic refresh_en;   // refresh active on both sides
   wire logic tx_alive;     // input side powered, after the synchroniser
   wire logic refresh_armed; // a refresh could be sent right now
   // between thresholds either state may result; a tie keeps high
   assign rx_level   = sync_p[1] | ~sync_n[1];
   // fixed variant ignores the pins; else both low enables needed
   assign refresh_en = FIXED_REFRESH | (~sync_ri[1] & ~sync_ro[1]);
   assign tx_alive   = sync_up[1];
   // idle timer only means something while a refresh could go out
   assign refresh_armed = tx_alive & refresh_en;

   logic             last_level;  // state last sent across
   logic [CNT_W-1:0] idle_cnt;    // cycles since last input change or refresh
   logic [CNT_W-1:0] pw_cnt;      // remaining pulse width
   logic             pulse_val;   // encoded state of the pulse
   wire  logic       edge_seen;   // input changed
   wire  logic       refresh_due; // idle long enough to resend
   wire  logic       fire;        // start a pulse this cycle

   assign edge_seen   = tx_alive & (rx_level != last_level);
   assign refresh_due = refresh_armed & (idle_cnt >= CNT_W'(IDLE_CYCLES - 1));
   assign fire        = (edge_seen | refresh_due) & (pw_cnt == '0);

   // encoder: one pulse per change, periodic resend when idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_level <= 1'b0;
         idle_cnt   <= '0;
         pw_cnt     <= '0;
         pulse_val  <= 1'b0;
      end else begin
         if (fire) begin
            last_level <= rx_level;
            pulse_val  <= rx_level;
            pw_cnt     <= CNT_W'(PULSE_CYC);
         end else if (pw_cnt != '0) begin
            pw_cnt <= pw_cnt - 1'b1;
         end
         // idle timer restarts on every change and every refresh;
         // held at zero while disarmed so a late enable sees no stale count
         if (edge_seen | refresh_due | ~refresh_armed) begin
            idle_cnt <= '0;
         end else begin
            idle_cnt <= idle_cnt + 1'b1;
         end
      end
   end

   wire logic pulse_on;      // pulse on the barrier
   assign pulse_on      = (pw_cnt != '0);
   assign set_pulse_o   = pulse_on & pulse_val;
   assign reset_pulse_o = pulse_on & ~pulse_val;

   // ------------------------------------------------------------
   // decoder and watchdog
   // ------------------------------------------------------------
   logic             dec_state;  // bistable decoder
   logic             failed;     // input side presumed dead
   logic [CNT_W-1:0] wd_cnt;     // cycles since last pulse
   wire  logic       any_pulse;  // a pulse arrived
   assign any_pulse = set_pulse_o | reset_pulse_o;

   // decoder holds between pulses; watchdog restarts on any pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dec_state <= DEC_RST_LVL;
         wd_cnt    <= '0;
         failed    <= 1'b0;
      end else begin
         if (set_pulse_o) begin
            dec_state <= 1'b1;
         end else if (reset_pulse_o) begin
            dec_state <= 1'b0;
         end
         if (any_pulse) begin
            wd_cnt <= '0;
            failed <= 1'b0;
         end else if (wd_cnt >= CNT_W'(FAIL_CYCLES - 1)) begin
            failed <= 1'b1;
         end else begin
            wd_cnt <= wd_cnt + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // output driver
   // ------------------------------------------------------------
   wire logic out_level;  // logic level presented on the pair
   // fail-safe only bites with refresh off, or the input side silent
   assign out_level = failed ? FAILSAFE_LVL : dec_state;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diff_output_pair_p_o <= FAILSAFE_LVL;
         diff_output_pair_n_o <= ~FAILSAFE_LVL;
      end else begin
         diff_output_pair_p_o <= out_level;
         diff_output_pair_n_o <= ~out_level;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_set_drives_high;
      @(posedge clk_i) disable iff (rst_i) set_pulse_o |=> dec_state;
   endproperty
   a_set_drives_high: assert property (p_set_drives_high) else $error("set lost");

   property p_reset_drives_low;
      @(posedge clk_i) disable iff (rst_i) reset_pulse_o |=> !dec_state;
   endproperty
   a_reset_drives_low: assert property (p_reset_drives_low) else $error("reset lost");

   property p_edge_pulses;
      @(posedge clk_i) disable iff (rst_i) (edge_seen && !pulse_on) |=> pulse_on;
   endproperty
   a_edge_pulses: assert property (p_edge_pulses) else $error("no pulse on edge");

   property p_pulse_value;
      @(posedge clk_i) disable iff (rst_i) fire |=> (set_pulse_o == $past(rx_level));
   endproperty
   a_pulse_value: assert property (p_pulse_value) else $error("wrong pulse kind");

   property p_refresh_bound;
      @(posedge clk_i) disable iff (rst_i)
         refresh_armed |-> idle_cnt < CNT_W'(IDLE_CYCLES);
   endproperty
   a_refresh_bound: assert property (p_refresh_bound) else $error("refresh late");

   property p_no_refresh_when_off;
      @(posedge clk_i) disable iff (rst_i) (fire && !refresh_en) |-> edge_seen;
   endproperty
   a_no_refresh_when_off: assert property (p_no_refresh_when_off) else $error("stray tx");

   // a pulse fits one core cycle, so set and reset never smear together
   property p_single_pulse;
      @(posedge clk_i) disable iff (rst_i) pulse_on |=> !pulse_on;
   endproperty
   a_single_pulse: assert property (p_single_pulse) else $error("pulse too long");

   // a dead input side sends nothing across the barrier
   property p_dead_side_silent;
      @(posedge clk_i) disable iff (rst_i) !tx_alive |=> !pulse_on;
   endproperty
   a_dead_side_silent: assert property (p_dead_side_silent) else $error("dead side sent");

   // silence past the limit must trip the fail-safe
   property p_watchdog_fires;
      @(posedge clk_i) disable iff (rst_i)
         (!any_pulse && wd_cnt >= CNT_W'(FAIL_CYCLES - 1)) |=> failed;
   endproperty
   a_watchdog_fires: assert property (p_watchdog_fires) else $error("watchdog silent");

   // any pulse proves the input side alive again
   property p_pulse_clears_fail;
      @(posedge clk_i) disable iff (rst_i) any_pulse |=> !failed;
   endproperty
   a_pulse_clears_fail: assert property (p_pulse_clears_fail) else $error("fail stuck");

   property p_failsafe_high;
      @(posedge clk_i) disable iff (rst_i) failed |=> diff_output_pair_p_o;
   endproperty
   a_failsafe_high: assert property (p_failsafe_high) else $error("fail-safe not high");

   property p_pair_opposite;
      @(posedge clk_i) disable iff (rst_i) diff_output_pair_p_o != diff_output_pair_n_o;
   endproperty
   a_pair_opposite: assert property (p_pair_opposite) else $error("pair not opposite");

   property p_follow_decoder;
      @(posedge clk_i) disable iff (rst_i) !failed |=> diff_output_pair_p_o == $past(dec_state);
   endproperty
   a_follow_decoder: assert property (p_follow_decoder) else $error("not following");
endmodule

// >>> bench/ierl_link_partner.sv
// upstream driver and downstream receiver models around one channel
`timescale 1ns/1ps
module ierl_link_partner (
   input  wire logic clk_i,            // core clock
   input  wire logic level_i,          // level the upstream driver sends
   input  wire logic ref_tie_n_i,      // board tie of the refresh enables
   input  wire logic out_p_i,          // noninverted output seen downstream
   input  wire logic out_n_i,          // inverted output seen downstream
   output logic      in_p_o,           // noninverted leg sent upstream
   output logic      in_n_o,           // inverted leg sent upstream
   output logic      refresh_in_n_o,   // input-side enable pin
   output logic      refresh_out_n_o,  // output-side enable pin
   output logic      rx_level_o        // level the receiver decodes
);
   // ---------------------------------------------
   // full swing legs, never inside the dead band
   // ---------------------------------------------
   assign in_p_o = level_i;
   assign in_n_o = ~level_i;
   // ground tie enables refresh, supply tie disables it
   assign refresh_in_n_o  = ref_tie_n_i;
   assign refresh_out_n_o = ref_tie_n_i;
   // non-complementary pair decodes as unknown so it can never match
   assign rx_level_o = (out_p_i === 1'b1 && out_n_i === 1'b0) ? 1'b1 :
                       (out_p_i === 1'b0 && out_n_i === 1'b1) ? 1'b0 : 1'bx;
endmodule

// >>> bench/ierl_channel_tb_top.sv
// self-checking bench for the isolated edge pulse channel
`timescale 1ns/1ps
module ierl_channel_tb_top;
   import ierl_pkg::*;
   localparam int unsigned IDLE_T = 8;   // shortened idle time
   localparam int unsigned FAIL_T = 12;  // shortened watchdog, above idle time
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic level = 1'b0;                   // wanted upstream level
   logic ref_n = 1'b0;                   // board tie of refresh pins
   logic up    = 1'b1;                   // input side powered
   logic in_p, in_n, rin_n, rout_n, out_p, out_n, set_p, rst_p, rx, fix_p, fix_n;
   int   fails = 0;
   int   tests_run = 0;
   int   sets = 0;                       // set pulses since last clear
   int   resets = 0;                     // reset pulses since last clear
   logic [1:0] rows [5] = '{2'b11, 2'b00, 2'b11, 2'b11, 2'b00};  // level, tally checked
   // ---------------------------------------------
   // clock, partner, designs
   // ---------------------------------------------
   initial forever #4 clk_i = ~clk_i;
   ierl_link_partner u_prt (.clk_i(clk_i), .level_i(level), .ref_tie_n_i(ref_n),
      .out_p_i(out_p), .out_n_i(out_n), .in_p_o(in_p), .in_n_o(in_n),
      .refresh_in_n_o(rin_n), .refresh_out_n_o(rout_n), .rx_level_o(rx));
   ierl_channel #(.IDLE_CYCLES(IDLE_T), .FAIL_CYCLES(FAIL_T)) u_dut (.clk_i(clk_i),
      .rst_i(rst_i), .diff_input_pair_p_i(in_p), .diff_input_pair_n_i(in_n),
      .refresh_in_n_i(rin_n), .refresh_out_n_i(rout_n), .input_side_up_i(up),
      .diff_output_pair_p_o(out_p), .diff_output_pair_n_o(out_n),
      .set_pulse_o(set_p), .reset_pulse_o(rst_p));
   // fixed variant: enables tied off, refresh must still run
   ierl_channel #(.FIXED_REFRESH(1'b1), .IDLE_CYCLES(IDLE_T), .FAIL_CYCLES(FAIL_T)) u_fix (
      .clk_i(clk_i), .rst_i(rst_i), .diff_input_pair_p_i(in_p),
      .diff_input_pair_n_i(in_n), .refresh_in_n_i(1'b1), .refresh_out_n_i(1'b1),
      .input_side_up_i(up), .diff_output_pair_p_o(fix_p),
      .diff_output_pair_n_o(fix_n), .set_pulse_o(), .reset_pulse_o());
   // pulse tally, cleared by the sequence on falling edges
   always @(posedge clk_i) begin
      if (set_p === 1'b1) sets++;
      if (rst_p === 1'b1) resets++;
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic check(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1) begin
         fails++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // watchdog far beyond the expected run of about 160 cycles
   initial begin
      repeat (3000) @(posedge clk_i);
      fails++;
      $display("[FAIL] %0t run hung", $time);
      stop_test();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      step(3);
      check(out_p === 1'b1 && out_n === 1'b0, "reset output");
      rst_i = 1'b0;
      step(IDLE_T + 8);
      check(rx === 1'b0 && resets >= 1, "power-up not corrected");
      $display("test reset done");
      // changes spaced well apart for the channel rate; the tally opens once
      // the new level is through the synchronisers, so a refresh of the old
      // level just before the change is not counted as an edge pulse
      foreach (rows[i]) begin
         level = rows[i][1];
         step(3);
         sets = 0;
         resets = 0;
         step(4);
         check(rx === rows[i][1], "output level");
         if (rows[i][0]) begin
            check(sets == int'(level) && resets == int'(!level), "edge pulse");
         end
      end
      $display("test table done");
      sets = 0;
      resets = 0;
      step(3 * IDLE_T);
      check(resets >= 2 && sets == 0 && rx === 1'b0, "refresh");
      ref_n = 1'b1;
      step(IDLE_T);
      sets = 0;
      resets = 0;
      step(FAIL_T + 8);
      check(sets == 0 && resets == 0, "refresh not off");
      check(rx === FAILSAFE_LVL, "no fail-safe");
      check(fix_p === 1'b0 && fix_n === 1'b1, "fixed refresh");
      level = 1'b1;
      step(7);
      level = 1'b0;
      step(7);
      check(rx === 1'b0, "transition fix");
      ref_n = 1'b0;
      up = 1'b0;
      step(3);
      sets = 0;
      resets = 0;
      step(FAIL_T + 8);
      check(rx === 1'b1 && sets == 0 && resets == 0, "unpowered side");
      // second reset with the input high: decoder restarts low and must catch up
      up = 1'b1;
      level = 1'b1;
      step(3);
      rst_i = 1'b1;
      step(3);
      check(out_p === 1'b1 && out_n === 1'b0, "mid-run reset output");
      rst_i = 1'b0;
      step(IDLE_T);
      check(rx === 1'b1 && fix_p === 1'b1, "power-up high");
      $display("test awkward done");
      stop_test();
   end
endmodule
